/* File: hw/vrc_ctrl.sv */
/*
 Video DRAM random-port controller with AXI4-Lite registers and refresh.
 Assumes a 100 MHz clock and data pins sampled on it.
*/
// Overview of operation
// [RL1] Output/transfer select stays high at every row strobe fall.
// [RL2] Device latches row at row fall, column at first column fall.
// [RL3] Either column strobe low at row fall means column-before-row.
// [RL4] Column-first, write low, select high: refresh and load stop point.
// [RL5] Column-first, write high, select low: refresh clearing mask modes.
// [RL6] Column-first, write and select high: refresh keeping modes.
// [RL7] Masked write takes lane mask from data pins at row fall.
// [RL8] Select high at column fall gives block write from A2-A8.
// [RL9] Persistent mask mode ignores row-fall data and uses stored mask.
// [RL10] Write high, select low at row fall: unmasked write or block.
// [RL11] Select high at row fall loads mask or colour register.
// [RL12] High mask bits enable lanes and columns; low bits inhibit.
// [RL13] Data captured at later of column fall and write fall.
// [RL14] Column or block address captured on first column fall.
// [RL15] Issue refresh-with-stop-point cycle first after power-up.
// [RL16] Page mode keeps the row open across column strobes.
// [RL17] Column-before-row refresh uses internal refresh row counter.
// [RL18] Every one of 512 rows refreshed within the refresh period.
// [RL19] Data outputs stay off through column-before-row refresh.
// [RL20] Holding column strobes after a read gives hidden refresh.
// [RL21] Row-only refresh: row strobe per row, outputs stay off.
// [RL22] Read data stays driven after column strobe rises.
// [RL23] Low column strobe gates low byte, high one upper byte.
// [RL24] Early write: write strobe low before column strobe falls.
// [RL25] Refresh counter advances after each refresh and wraps.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_regs.svh"

module vrc_ctrl #(
  parameter int PHASE_NS = `VRC_PHASE_NS,
  parameter int REF_PERIOD_US = `VRC_REF_PERIOD_US,
  parameter int ROWS = `VRC_ROWS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AXI4-Lite write channels
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output var logic wready,
  output var logic [1:0] bresp,
  output var logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output var logic arready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic rvalid,
  input wire logic rready,
  // DRAM random port
  output var logic row_strobe_n,
  output var logic low_byte_col_strobe_n,
  output var logic high_byte_col_strobe_n,
  output var logic write_strobe_n,
  output var logic output_or_transfer_select_n,
  output var logic function_select,
  output var logic [8:0] multiplexed_address,
  output var logic [15:0] random_data_o,
  output var logic random_data_oe,
  input wire logic [15:0] random_data_i
);

  localparam int PHASE_CYC = (PHASE_NS * `VRC_CLK_MHZ + 999) / 1000;
  localparam int REF_CYC = (REF_PERIOD_US * `VRC_CLK_MHZ) / ROWS;
  localparam logic [7:0] PH = 8'(PHASE_CYC - 1);

  generate
    if (PHASE_CYC < 1 || PHASE_CYC > 256 || ROWS < 1) begin : g_bad
      $error("phase time or row count out of range");
    end
  endgenerate

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of cycle kinds

  function automatic logic is_cbr(vrc_pkg::vrc_cmd_t c);
    return c inside {vrc_pkg::VRC_REF_STOP, vrc_pkg::VRC_REF_RESET,
                     vrc_pkg::VRC_REF_KEEP};
  endfunction

  function automatic logic is_wr(vrc_pkg::vrc_cmd_t c);
    return c inside {vrc_pkg::VRC_WRITE, vrc_pkg::VRC_WRITE_MASKED,
                     vrc_pkg::VRC_BLOCK, vrc_pkg::VRC_BLOCK_MASKED,
                     vrc_pkg::VRC_LOAD_MASK, vrc_pkg::VRC_LOAD_COLOR};
  endfunction

  // Write strobe level at row fall selects masking
  function automatic logic row_we_low(vrc_pkg::vrc_cmd_t c);
    return c inside {vrc_pkg::VRC_WRITE_MASKED, vrc_pkg::VRC_BLOCK_MASKED,
                     vrc_pkg::VRC_REF_STOP};
  endfunction

  function automatic logic row_dsf(vrc_pkg::vrc_cmd_t c);
    return c inside {vrc_pkg::VRC_LOAD_MASK, vrc_pkg::VRC_LOAD_COLOR,
                     vrc_pkg::VRC_REF_STOP, vrc_pkg::VRC_REF_KEEP};
  endfunction

  function automatic logic col_dsf(vrc_pkg::vrc_cmd_t c);
    return c inside {vrc_pkg::VRC_BLOCK, vrc_pkg::VRC_BLOCK_MASKED,
                     vrc_pkg::VRC_LOAD_COLOR};
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Refresh timer

  vrc_refresh_if rif ();

  vrc_refresh_timer #(.INTERVAL(REF_CYC)) u_timer (
    .clock(clock),
    .reset(reset),
    .rif(rif.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave

  logic [31:0] ctrl_q, ctrl_d, addr_q, addr_d, data_q, data_d;
  logic pend_q, pend_d, err_q, err_d;
  vrc_pkg::vrc_cmd_t sel_q, sel_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d, stat;
  logic take_sw, take_ref, go, busy;
  logic [15:0] rd_q, rd_d;
  logic init_q, init_d;
  vrc_pkg::vrc_state_t st_q, st_d;

  assign busy = (st_q != vrc_pkg::VRC_IDLE);

  always_comb begin
    stat = '0;
    stat[`VRC_STAT_BUSY] = busy;
    stat[`VRC_STAT_PEND] = pend_q;
    stat[`VRC_STAT_ERR] = err_q;
    stat[`VRC_STAT_INIT] = init_q;
    stat[`VRC_STAT_RD] = rd_q;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    data_d = data_q;
    pend_d = pend_q;
    err_d = err_q;
    sel_d = sel_q;
    awready_d = 1'b0;
    wready_d = 1'b0;
    bvalid_d = bvalid;
    bresp_d = bresp;
    arready_d = 1'b0;
    rvalid_d = rvalid;
    rresp_d = rresp;
    rdata_d = rdata;
    if (take_sw) begin
      pend_d = 1'b0;
    end
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (awready) begin
      bvalid_d = 1'b1;
      bresp_d = `VRC_RESP_OK;
      unique case (awaddr)
        `VRC_OFF_CTRL: ctrl_d = merge(ctrl_q, wdata, wstrb);
        `VRC_OFF_ADDR: addr_d = merge(addr_q, wdata, wstrb);
        `VRC_OFF_DATA: data_d = merge(data_q, wdata, wstrb);
        `VRC_OFF_STAT: err_d = 1'b0;
        `VRC_OFF_CMD: begin
          // Unknown codes and orders given while one waits are refused
          if (wstrb[0]) begin
            if (pend_q || wdata[`VRC_CMD_CODE] > 4'ha) begin
              err_d = 1'b1;
            end else begin
              pend_d = 1'b1;
              sel_d = vrc_pkg::vrc_cmd_t'(wdata[`VRC_CMD_CODE]);
            end
          end
        end
        default: bresp_d = `VRC_RESP_SLVERR;
      endcase
    end else if (!bvalid && awvalid && wvalid) begin
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    if (arready) begin
      rvalid_d = 1'b1;
      rresp_d = `VRC_RESP_OK;
      unique case (araddr)
        `VRC_OFF_CTRL: rdata_d = ctrl_q;
        `VRC_OFF_CMD: rdata_d = {28'h0, sel_q};
        `VRC_OFF_ADDR: rdata_d = addr_q;
        `VRC_OFF_DATA: rdata_d = data_q;
        `VRC_OFF_STAT: rdata_d = stat;
        default: begin
          rdata_d = '0;
          rresp_d = `VRC_RESP_SLVERR;
        end
      endcase
    end else if (!rvalid && arvalid) begin
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q <= `VRC_CTRL_RST;
      addr_q <= '0;
      data_q <= '0;
      pend_q <= 1'b0;
      err_q <= 1'b0;
      sel_q <= vrc_pkg::VRC_READ;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      data_q <= data_d;
      pend_q <= pend_d;
      err_q <= err_d;
      sel_q <= sel_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rresp <= rresp_d;
      rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencer

  logic [7:0] cnt_q, cnt_d;
  vrc_pkg::vrc_cmd_t cmd_q, cmd_d, pick;
  logic row_d, lo_d, hi_d, we_d, trg_d, dsf_d, oe_d, rel;
  logic [8:0] ma_d;
  logic [15:0] dq_d;
  logic lane_lo, lane_hi, en_q, ack_q, ack_d;

  // No lane enabled is taken as both
  assign lane_lo = ctrl_q[`VRC_CTRL_LOW] | ~ctrl_q[`VRC_CTRL_HIGH];
  assign lane_hi = ctrl_q[`VRC_CTRL_HIGH] | ~ctrl_q[`VRC_CTRL_LOW];
  assign rif.en = en_q;
  assign rif.ack = ack_q;

  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != 8'h0) ? cnt_q - 8'h1 : cnt_q;
    cmd_d = cmd_q;
    row_d = row_strobe_n;
    lo_d = low_byte_col_strobe_n;
    hi_d = high_byte_col_strobe_n;
    we_d = write_strobe_n;
    trg_d = output_or_transfer_select_n;
    dsf_d = function_select;
    ma_d = multiplexed_address;
    dq_d = random_data_o;
    oe_d = random_data_oe;
    rd_d = rd_q;
    init_d = init_q;
    ack_d = 1'b0;
    take_sw = 1'b0;
    take_ref = 1'b0;
    go = 1'b0;
    rel = 1'b0;
    pick = vrc_pkg::VRC_REF_KEEP;
    unique case (st_q)
      vrc_pkg::VRC_IDLE: begin
        // [RL15] stop point first
        if (!init_q) begin
          pick = vrc_pkg::VRC_REF_STOP;
          go = 1'b1;
          init_d = 1'b1;
        end else if (pend_q) begin
          pick = sel_q;
          go = 1'b1;
          take_sw = 1'b1;
        end else if (rif.req) begin
          // [RL18] periodic row refresh
          go = 1'b1;
          take_ref = 1'b1;
          ack_d = 1'b1;
        end
        if (go) begin
          cmd_d = pick;
          cnt_d = PH;
          we_d = ~row_we_low(pick);
          dsf_d = row_dsf(pick);
          // [RL1] select high at row fall
          trg_d = 1'b1;
          if (is_cbr(pick)) begin
            st_d = vrc_pkg::VRC_CBR_COL;
            lo_d = 1'b0;
            hi_d = 1'b0;
            oe_d = 1'b0;
            ma_d = 9'(ctrl_q[`VRC_CTRL_STOP]) << `VRC_STOP_SHIFT;
          end else begin
            st_d = vrc_pkg::VRC_ROW_SETUP;
            ma_d = addr_q[`VRC_ADDR_ROW];
            dq_d = data_q[`VRC_DATA_MASK];
            oe_d = row_we_low(pick);
          end
        end
      end
      vrc_pkg::VRC_CBR_COL, vrc_pkg::VRC_ROW_SETUP: begin
        if (cnt_q == 8'h0) begin
          st_d = vrc_pkg::VRC_ROW_LOW;
          row_d = 1'b0;
          cnt_d = PH;
        end
      end
      vrc_pkg::VRC_ROW_LOW: begin
        if (cnt_q == 8'h0) begin
          // [RL21] row only, no column strobe
          if (is_cbr(cmd_q) || cmd_q == vrc_pkg::VRC_ROW_ONLY) begin
            rel = 1'b1;
          end else begin
            // [RL24] write strobe low ahead of column
            st_d = vrc_pkg::VRC_COL_SETUP;
            cnt_d = PH;
            ma_d = addr_q[`VRC_ADDR_COL];
            dsf_d = col_dsf(cmd_q);
            we_d = ~is_wr(cmd_q);
            dq_d = data_q[`VRC_DATA_WR];
            oe_d = is_wr(cmd_q);
          end
        end
      end
      vrc_pkg::VRC_COL_SETUP: begin
        if (cnt_q == 8'h0) begin
          st_d = vrc_pkg::VRC_COL_LOW;
          cnt_d = PH;
          lo_d = ~lane_lo;
          hi_d = ~lane_hi;
          trg_d = is_wr(cmd_q);
        end
      end
      vrc_pkg::VRC_COL_LOW: begin
        if (cnt_q == 8'h0) begin
          if (cmd_q == vrc_pkg::VRC_READ) begin
            rd_d = random_data_i;
          end
          rel = 1'b1;
        end
      end
      vrc_pkg::VRC_PRECHARGE: begin
        if (cnt_q == 8'h0) begin
          st_d = vrc_pkg::VRC_IDLE;
        end
      end
    endcase
    if (rel) begin
      st_d = vrc_pkg::VRC_PRECHARGE;
      cnt_d = PH;
      row_d = 1'b1;
      lo_d = 1'b1;
      hi_d = 1'b1;
      we_d = 1'b1;
      trg_d = 1'b1;
      dsf_d = 1'b0;
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= vrc_pkg::VRC_IDLE;
      cnt_q <= 8'h0;
      cmd_q <= vrc_pkg::VRC_READ;
      row_strobe_n <= 1'b1;
      low_byte_col_strobe_n <= 1'b1;
      high_byte_col_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_or_transfer_select_n <= 1'b1;
      function_select <= 1'b0;
      multiplexed_address <= 9'h0;
      random_data_o <= 16'h0;
      random_data_oe <= 1'b0;
      rd_q <= 16'h0;
      init_q <= 1'b0;
      ack_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      row_strobe_n <= row_d;
      low_byte_col_strobe_n <= lo_d;
      high_byte_col_strobe_n <= hi_d;
      write_strobe_n <= we_d;
      output_or_transfer_select_n <= trg_d;
      function_select <= dsf_d;
      multiplexed_address <= ma_d;
      random_data_o <= dq_d;
      random_data_oe <= oe_d;
      rd_q <= rd_d;
      init_q <= init_d;
      ack_q <= ack_d;
      en_q <= ctrl_q[`VRC_CTRL_AUTO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int REF_SLACK = 12 * PHASE_CYC + 8;
  logic seen_q;
  logic [31:0] since_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seen_q <= 1'b0;
      since_q <= '0;
    end else begin
      if (!row_strobe_n) begin
        seen_q <= 1'b1;
      end
      if (!en_q || take_ref || pend_q || busy) begin
        since_q <= '0;
      end else begin
        since_q <= since_q + 32'h1;
      end
    end
  end

  property p_row_select;
      $fell(row_strobe_n) |-> output_or_transfer_select_n;
  endproperty
  a_row_select: assert property (p_row_select) // RL1
    else $error("select low at row fall");

  property p_first_stop;
      ($fell(row_strobe_n) && !seen_q) |->
        (!low_byte_col_strobe_n && !write_strobe_n && function_select);
  endproperty
  a_first_stop: assert property (p_first_stop) // RL15
    else $error("first cycle is not the stop point refresh");

  property p_refresh_due;
      since_q <= 32'(REF_CYC + REF_SLACK);
  endproperty
  a_refresh_due: assert property (p_refresh_due) // RL18
    else $error("refresh overdue");

  property p_row_only;
      (cmd_q == vrc_pkg::VRC_ROW_ONLY && !row_strobe_n) |->
        (low_byte_col_strobe_n && high_byte_col_strobe_n &&
         !random_data_oe);
  endproperty
  a_row_only: assert property (p_row_only) // RL21
    else $error("column strobe or data driven in row-only refresh");

  property p_early_write;
      (($fell(low_byte_col_strobe_n) || $fell(high_byte_col_strobe_n)) &&
       is_wr(cmd_q)) |-> ($past(write_strobe_n) == 1'b0 && random_data_oe);
  endproperty
  a_early_write: assert property (p_early_write) // RL24
    else $error("write strobe not low before column fall");

  c_read: cover property (st_q == vrc_pkg::VRC_COL_LOW &&
    cmd_q == vrc_pkg::VRC_READ);
  c_block: cover property (st_q == vrc_pkg::VRC_COL_LOW &&
    cmd_q == vrc_pkg::VRC_BLOCK_MASKED);
  c_refresh: cover property (take_ref ##[1:40] $fell(row_strobe_n));

endmodule

`default_nettype wire

/* File: hw/vrc_regs.svh */
/*
 Register map and timing figures of the random-port controller.
 Assumes a 100 MHz clock and word-aligned bus accesses.
*/
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH

// Register offsets (byte addresses)
`define VRC_OFF_CTRL 5'h00
`define VRC_OFF_CMD 5'h04
`define VRC_OFF_ADDR 5'h08
`define VRC_OFF_DATA 5'h0c
`define VRC_OFF_STAT 5'h10

// Control fields
`define VRC_CTRL_AUTO 0
`define VRC_CTRL_LOW 1
`define VRC_CTRL_HIGH 2
`define VRC_CTRL_STOP 7:4
`define VRC_CTRL_RST 32'h0000_0006

// Command, address and data fields
`define VRC_CMD_CODE 3:0
`define VRC_ADDR_ROW 8:0
`define VRC_ADDR_COL 24:16
`define VRC_DATA_WR 15:0
`define VRC_DATA_MASK 31:16
`define VRC_STOP_SHIFT 4

// Status fields
`define VRC_STAT_BUSY 0
`define VRC_STAT_PEND 1
`define VRC_STAT_ERR 2
`define VRC_STAT_INIT 3
`define VRC_STAT_RD 31:16

// Bus answers
`define VRC_RESP_OK 2'h0
`define VRC_RESP_SLVERR 2'h2

// Timing figures
`define VRC_CLK_MHZ 100
`define VRC_PHASE_NS 20
`define VRC_REF_PERIOD_US 8000
`define VRC_ROWS 512

`endif

/* File: hw/vrc_pkg.sv */
/*
 Types shared by the random-port controller and the behavioural DRAM model.
 Assumes nothing of its surroundings.
*/
package vrc_pkg;

  // Random-port cycle kinds that software may order
  typedef enum logic [3:0] {
    VRC_READ,
    VRC_WRITE,
    VRC_WRITE_MASKED,
    VRC_BLOCK,
    VRC_BLOCK_MASKED,
    VRC_LOAD_MASK,
    VRC_LOAD_COLOR,
    VRC_REF_STOP,
    VRC_REF_RESET,
    VRC_REF_KEEP,
    VRC_ROW_ONLY
  } vrc_cmd_t;

  typedef enum logic [2:0] {
    VRC_IDLE,
    VRC_CBR_COL,
    VRC_ROW_SETUP,
    VRC_ROW_LOW,
    VRC_COL_SETUP,
    VRC_COL_LOW,
    VRC_PRECHARGE
  } vrc_state_t;

endpackage

/* File: hw/vrc_refresh_if.sv */
/*
 Carrier between the controller and its refresh timer.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface vrc_refresh_if;
  logic en;
  logic req;
  logic ack;

  modport timer (input en, input ack, output req);
  modport ctrl (output en, output ack, input req);
endinterface

`default_nettype wire

/* File: hw/vrc_refresh_timer.sv */
/*
 Refresh interval timer: requests one refresh per row interval.
 Assumes the controller acknowledges with a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module vrc_refresh_timer #(
  parameter int INTERVAL = 1562
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Controller side
  vrc_refresh_if.timer rif
);

  generate
    if (INTERVAL < 2 || INTERVAL > 65535) begin : g_bad
      $error("refresh interval out of range");
    end
  endgenerate

  logic [15:0] cnt_q, cnt_d;
  logic req_q, req_d;
  logic tick;

  assign rif.req = req_q;

  always_comb begin
    cnt_d = cnt_q;
    req_d = req_q;
    tick = 1'b0;
    if (!rif.en) begin
      cnt_d = '0;
    end else if (cnt_q == 16'(INTERVAL - 1)) begin
      cnt_d = '0;
      tick = 1'b1;
    end else begin
      cnt_d = cnt_q + 16'h1;
    end
    if (rif.ack) begin
      req_d = 1'b0;
    end
    // A tick landing on the acknowledge cycle is kept
    if (tick) begin
      req_d = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      req_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      req_q <= req_d;
    end
  end

  property p_req_held;
    @(posedge clock) disable iff (reset)
      (req_q && !rif.ack) |=> req_q;
  endproperty
  a_req_held: assert property (p_req_held)
    else $error("refresh request dropped without acknowledge");

endmodule

`default_nettype wire

/* File: sim/vrc_dram_model.sv */
/*
 Behavioural random port of the video DRAM.
 Assumes early writes; the bench takes random_data_i from here.
*/
`timescale 1ns/1ps
`default_nettype none

module vrc_dram_model (
  // Strobes and selects
  input wire logic row_strobe_n,
  input wire logic low_byte_col_strobe_n,
  input wire logic high_byte_col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic output_or_transfer_select_n,
  input wire logic function_select,
  input wire logic [8:0] multiplexed_address,
  // Data pins, resolved here
  input wire logic [15:0] random_data_o,
  input wire logic random_data_oe,
  output logic [15:0] random_data_i
);
  logic [15:0] mem [512];
  logic [15:0] mask_q, row_mask_q, color_q, last_q, rd_q;
  logic [3:0] stop_q;
  logic [8:0] ref_row_q, col_q;
  logic persist_q, cbr_q, we_row_q, fs_row_q, col_seen_q, rd_en_q;
  int refreshes;
  vrc_pkg::vrc_cmd_t kind_q;
  wire colx_n = low_byte_col_strobe_n & high_byte_col_strobe_n;
  wire [15:0] lanes = {{8{~high_byte_col_strobe_n}}, {8{~low_byte_col_strobe_n}}};
  // output only for a read, held past column rise
  wire dev_en = rd_en_q & ~output_or_transfer_select_n & write_strobe_n;
  wire [15:0] drv = random_data_oe ? random_data_o : rd_q;

  initial begin
    persist_q = 0;
    ref_row_q = 9'h0;
    refreshes = 0;
    rd_en_q = 0;
    last_q = 16'h0;
  end

  // Undriven pins show the inverse of the last value, no pull-ups
  always @* if (random_data_oe || dev_en) last_q = drv;
  assign random_data_i = (random_data_oe || dev_en) ? drv : ~last_q;

  task automatic put(input logic [15:0] m);
    mem[col_q] = (mem[col_q] & ~m) | (random_data_i & m);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // decode at row fall
  always @(negedge row_strobe_n) begin
    cbr_q = ~colx_n;
    we_row_q = write_strobe_n;
    fs_row_q = function_select;
    row_mask_q = persist_q ? mask_q : random_data_i;
    col_seen_q = 0;
    if (cbr_q) begin
      ref_row_q = ref_row_q + 9'h1;
      refreshes++;
      case ({write_strobe_n, function_select})
        2'h1: begin
          kind_q = vrc_pkg::VRC_REF_STOP;
          stop_q = multiplexed_address[7:4];
        end
        2'h2: begin
          kind_q = vrc_pkg::VRC_REF_RESET;
          persist_q = 0;
        end
        default: kind_q = vrc_pkg::VRC_REF_KEEP;
      endcase
    end
  end

  always @(negedge colx_n) if (!row_strobe_n && !cbr_q && !col_seen_q) begin
    col_seen_q = 1;
    col_q = multiplexed_address;
    if (write_strobe_n) begin
      kind_q = vrc_pkg::VRC_READ;
      rd_q = mem[col_q];
      rd_en_q = 1;
    end else begin
      case ({we_row_q, fs_row_q, function_select})
        3'h0: begin
          kind_q = vrc_pkg::VRC_WRITE_MASKED;
          put(row_mask_q & lanes);
        end
        3'h1: kind_q = vrc_pkg::VRC_BLOCK_MASKED;
        3'h4: begin
          kind_q = vrc_pkg::VRC_WRITE;
          put(lanes);
        end
        3'h5: kind_q = vrc_pkg::VRC_BLOCK;
        3'h6: begin
          kind_q = vrc_pkg::VRC_LOAD_MASK;
          mask_q = (mask_q & ~lanes) | (random_data_i & lanes);
          persist_q = 1;
        end
        default: begin
          kind_q = vrc_pkg::VRC_LOAD_COLOR;
          color_q = (color_q & ~lanes) | (random_data_i & lanes);
        end
      endcase
    end
  end

  // row-only seen at row rise; read data ends
  always @(posedge row_strobe_n or posedge colx_n) begin
    if (row_strobe_n && !cbr_q && !col_seen_q) kind_q = vrc_pkg::VRC_ROW_ONLY;
    if (row_strobe_n && colx_n) rd_en_q = 0;
  end
endmodule

`default_nettype wire

/* File: sim/vrc_ctrl_test.sv */
/*
 Self-checking bench for the random-port controller.
 Assumes the device model in vrc_dram_model and AXI4-Lite at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module vrc_ctrl_test;
  logic clock, reset, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, val;
  logic [3:0] wstrb, c;
  logic [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, row_strobe_n, write_strobe_n;
  wire low_byte_col_strobe_n, high_byte_col_strobe_n, function_select;
  wire random_data_oe, output_or_transfer_select_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [8:0] multiplexed_address;
  wire [15:0] random_data_o, random_data_i;
  int miscompares, samples_checked, cycles;

  vrc_ctrl #(.REF_PERIOD_US(100)) dut_u (.clock, .reset, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .row_strobe_n, .low_byte_col_strobe_n, .high_byte_col_strobe_n,
    .write_strobe_n, .output_or_transfer_select_n, .function_select,
    .multiplexed_address, .random_data_o, .random_data_oe, .random_data_i);

  vrc_dram_model dev_u (.row_strobe_n, .low_byte_col_strobe_n,
    .high_byte_col_strobe_n, .write_strobe_n, .output_or_transfer_select_n,
    .function_select, .multiplexed_address, .random_data_o,
    .random_data_oe, .random_data_i);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge clock); while (awready !== 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    while (bvalid !== 1'h1) @(posedge clock);
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [4:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge clock);
    val = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask

  // Order one cycle, wait until idle
  task automatic run(input logic [3:0] code);
    axw(5'h04, {28'h0, code});
    do axr(5'h10); while (val[1:0] !== 2'h0);
  endtask

  task automatic t_init();
    do axr(5'h10); while (val[3] !== 1'h1);
    chk(dev_u.kind_q, 32'h7, "first refresh kind");
    chk(dev_u.stop_q, 32'h0, "stop code");
    axr(5'h00);
    chk(val, 32'h6, "control reset");
    axr(5'h14);
    chk(resp, 32'h2, "unmapped read");
    axw(5'h18, 32'h0);
    chk(resp, 32'h2, "unmapped write");
    $display("test init done");
  endtask

  task automatic t_data();
    axw(5'h08, 32'h0155_00a3);
    axw(5'h0c, 32'h0000_1234);
    run(4'h1);
    run(4'h0);
    chk(val[31:16], 32'h1234, "read back");
    chk(dev_u.col_q, 32'h155, "column latched");
    axw(5'h0c, 32'h00ff_abcd);
    run(4'h2);
    run(4'h0);
    chk(val[31:16], 32'h12cd, "masked write");
    axw(5'h00, 32'h2);
    axw(5'h0c, 32'h0000_5678);
    run(4'h1);
    axw(5'h00, 32'h6);
    run(4'h0);
    chk(val[31:16], 32'h1278, "low lane only");
    $display("test data done");
  endtask

  task automatic t_modes();
    int n;
    n = dev_u.refreshes;
    axw(5'h0c, 32'h0000_000f);
    run(4'h5);
    chk(dev_u.persist_q, 32'h1, "mask mode on");
    axw(5'h0c, 32'h0000_0000);
    run(4'h2);
    run(4'h0);
    chk(val[31:16], 32'h1270, "stored mask used");
    axw(5'h0c, 32'h0000_a5a5);
    run(4'h6);
    chk(dev_u.color_q, 32'ha5a5, "colour loaded");
    run(4'h9);
    chk(dev_u.persist_q, 32'h1, "mask mode kept");
    run(4'h8);
    chk(dev_u.persist_q, 32'h0, "mask mode cleared");
    axw(5'h00, 32'h96);
    run(4'h7);
    chk(dev_u.stop_q, 32'h9, "stop code loaded");
    chk(dev_u.refreshes - n, 32'h3, "refresh count");
    $display("test modes done");
  endtask

  task automatic t_kinds();
    for (c = 4'h0; c <= 4'ha; c++) begin
      run(c);
      chk(dev_u.kind_q, c, "cycle kind");
    end
    $display("test kinds done");
  endtask

  task automatic t_auto();
    int n;
    n = dev_u.refreshes;
    axw(5'h00, 32'h7);
    repeat (100) @(posedge clock);
    chk(dev_u.refreshes - n >= 4, 32'h1, "timer refreshes");
    chk(dev_u.kind_q, 32'h9, "timer refresh kind");
    $display("test auto done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (!row_strobe_n && dev_u.cbr_q && random_data_oe)
      chk(32'h1, 32'h0, "data driven in refresh");
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 5'h0;
    araddr = 5'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    reset = 1;
    repeat (6) @(posedge clock);
    reset <= 0;
    t_init();
    t_data();
    t_modes();
    t_kinds();
    t_auto();
    conclude();
  end
endmodule

`default_nettype wire
